// *** src/nfhc_regs.svh ***
`ifndef NFHC_REGS_SVH
`define NFHC_REGS_SVH
// Command codes
`define NFHC_CMD_READ0 8'h00
`define NFHC_CMD_READ1 8'h01
`define NFHC_CMD_READ2 8'h50
`define NFHC_CMD_PROG_SETUP 8'h80
`define NFHC_CMD_PROG_EXEC 8'h10
`define NFHC_CMD_ERASE_SETUP 8'h60
`define NFHC_CMD_ERASE_EXEC 8'hd0
`define NFHC_CMD_STATUS 8'h70
`define NFHC_CMD_RESET 8'hff
// Address layout
`define NFHC_ADDR_BITS 27
`define NFHC_ROW_TOP_MASK 8'h03
// Strobe phase length in clock cycles (40 ns each)
`define NFHC_PHASE_NS 40
`define NFHC_CLK_NS 40
`define NFHC_PHASE_CYC ((`NFHC_PHASE_NS + `NFHC_CLK_NS - 1) / `NFHC_CLK_NS)
// Wait from write strobe high to busy valid: 200 ns
`define NFHC_WB_NS 200
`define NFHC_WB_CYC ((`NFHC_WB_NS + `NFHC_CLK_NS - 1) / `NFHC_CLK_NS)
`define NFHC_CNT_W 4
`endif

// *** src/nfhc_pkg.sv ***
package nfhc_pkg;
	// Operation requested by the user side
	typedef enum logic [2:0] {
		NFHC_OP_CMD,
		NFHC_OP_READ,
		NFHC_OP_PROGRAM,
		NFHC_OP_ERASE,
		NFHC_OP_STATUS
	} nfhc_op_t;
endpackage

// *** src/nfhc_fifo_if.sv ***
`timescale 1ns/10ps
// Stream between FIFO and controller
interface nfhc_fifo_if #(parameter int WIDTH = 8);
	logic [WIDTH-1:0] data;
	logic valid;
	logic ready;
	modport src (output data, output valid, input ready);
	modport dst (input data, input valid, output ready);
endinterface

// *** src/nfhc_fifo.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// Synchronous FIFO, width and depth parameters
// ----------------------------------------
module nfhc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clock_in,
	input wire logic rstn_in,
	nfhc_fifo_if.dst wr,
	nfhc_fifo_if.src rd
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH]; // Storage
	logic [AW-1:0] wp_reg, wp_next; // Write pointer
	logic [AW-1:0] rp_reg, rp_next; // Read pointer
	logic [AW:0] cnt_reg, cnt_next; // Fill level
	logic ready_reg, ready_next; // Not-full flag, registered
	logic push, pop;

	// Full flag from a flop so the top-level ready is glitch free
	assign wr.ready = ready_reg;
	assign rd.valid = (cnt_reg != '0);
	assign rd.data = mem_reg[rp_reg];
	assign push = wr.valid && wr.ready;
	assign pop = rd.valid && rd.ready;

	// Pointer and level update
	always_comb begin
		wp_next = wp_reg;
		rp_next = rp_reg;
		cnt_next = cnt_reg;
		if (push) begin
			wp_next = (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + AW'(1);
		end
		if (pop) begin
			rp_next = (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + AW'(1);
		end
		if (push && !pop) begin
			cnt_next = cnt_reg + (AW+1)'(1);
		end else if (pop && !push) begin
			cnt_next = cnt_reg - (AW+1)'(1);
		end
		// Ready drops the cycle the last slot fills
		ready_next = (cnt_next != (AW+1)'(DEPTH));
	end

	// Registers
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
			ready_reg <= 1'b1;
		end else begin
			wp_reg <= wp_next;
			rp_reg <= rp_next;
			cnt_reg <= cnt_next;
			ready_reg <= ready_next;
		end
	end

	// Storage has no reset; only written on push
	always_ff @(posedge clock_in) begin
		if (push) begin
			mem_reg[wp_reg] <= wr.data;
		end
	end
endmodule

// *** src/nfhc_host.sv ***
`timescale 1ns/10ps
// Function
// (RULE1) Command byte latched with command strobe high
// (RULE2) Address bytes latched with location strobe high
// (RULE3) All bytes taken on write strobe rise
// (RULE4) Chip select high aborts a read
// (RULE5) Chip select ignored while program/erase busy
// (RULE6) Each output strobe fall gives next byte
// (RULE7) Device floats port when deselected
// (RULE8) Write-protect low blocks program and erase
// (RULE9) Ready/busy low during program, erase, read
// (RULE10) Open-drain busy line, host pulls up
// (RULE11) Program page once, spare twice per erase
// (RULE12) Never program or erase invalid blocks
// (RULE13) Read/program: column plus three row bytes
// (RULE14) Erase: setup, three row bytes, execute
// (RULE15) Data bytes with both latch strobes low
// (RULE16) Program 200-500 us, erase 2-3 ms busy
`include "nfhc_regs.svh"
module nfhc_host #(
	parameter int DEPTH = 8
) (
	input wire logic clock_in,
	input wire logic rstn_in,
	// User request port
	input wire logic req_valid_in,
	input wire logic [2:0] req_op_in,
	input wire logic [7:0] req_cmd_in,
	input wire logic [`NFHC_ADDR_BITS-1:0] req_addr_in,
	input wire logic [9:0] req_len_in,
	output logic req_ready_out,
	output logic done_out,
	// Write data stream into FIFO
	input wire logic wdata_valid_in,
	input wire logic [7:0] wdata_in,
	output logic wdata_ready_out,
	// Read data stream out
	output logic rdata_valid_out,
	output logic [7:0] rdata_out,
	// Card pins
	output logic cmd_latch_out,
	output logic loc_latch_out,
	output logic chip_sel_n_out,
	output logic write_strobe_n_out,
	output logic output_strobe_n_out,
	output logic write_protect_n_out,
	input wire logic [7:0] shared_byte_port_in,
	output logic [7:0] shared_byte_port_out,
	output logic shared_byte_port_oe_out,
	input wire logic ready_busy_in
);
	// ----------------------------------------
	// Types and state
	// ----------------------------------------
	typedef enum logic [3:0] {
		S_IDLE, S_CMD, S_ADDR, S_WDATA, S_CMD2, S_WAIT_WB, S_WAIT_RDY, S_RDATA, S_DONE
	} nfhc_state_t;

	nfhc_state_t st_reg, st_next;
	logic [`NFHC_CNT_W-1:0] cnt_reg, cnt_next; // Phase / wait counter
	logic ph_reg, ph_next; // 0 = strobe low half, 1 = high half
	logic [2:0] op_reg, op_next; // Latched operation
	logic [7:0] cmd_reg, cmd_next; // Latched first command
	logic [`NFHC_ADDR_BITS-1:0] addr_reg, addr_next;
	logic [1:0] abyte_reg, abyte_next; // Address byte index
	logic [9:0] len_reg, len_next; // Remaining data bytes
	logic cle_reg, cle_next, ale_reg, ale_next, cs_n_reg, cs_n_next;
	logic we_n_reg, we_n_next, re_n_reg, re_n_next, wp_n_reg, wp_n_next;
	logic [7:0] dout_reg, dout_next;
	logic oe_reg, oe_next;
	logic rdy_reg, rdy_next, done_reg, done_next;
	logic rv_reg, rv_next;
	logic [7:0] rd_reg, rd_next;

	nfhc_fifo_if #(.WIDTH(8)) fin();
	nfhc_fifo_if #(.WIDTH(8)) fout();

	// ----------------------------------------
	// Write data buffer
	// ----------------------------------------
	assign fin.data = wdata_in;
	assign fin.valid = wdata_valid_in;
	nfhc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
		.clock_in(clock_in),
		.rstn_in(rstn_in),
		.wr(fin),
		.rd(fout)
	);

	// Address byte select for the cycle index
	function automatic logic [7:0] addr_byte(input logic [`NFHC_ADDR_BITS-1:0] a,
		input logic [1:0] i, input logic erase);
		logic [1:0] k;
		logic [7:0] b;
		k = erase ? i + 2'd1 : i; // Erase skips column byte
		case (k)
			2'd0: b = a[7:0];
			2'd1: b = a[16:9];
			2'd2: b = a[24:17];
			default: b = {6'h00, a[26:25]} & `NFHC_ROW_TOP_MASK; // Upper bits low
		endcase
		return b;
	endfunction

	// ----------------------------------------
	// Sequencer next state
	// ----------------------------------------
	always_comb begin
		logic phase_end;
		logic is_erase;
		phase_end = (cnt_reg == `NFHC_CNT_W'(`NFHC_PHASE_CYC - 1));
		is_erase = (op_reg == 3'(nfhc_pkg::NFHC_OP_ERASE));
		st_next = st_reg;
		cnt_next = phase_end ? '0 : cnt_reg + `NFHC_CNT_W'(1);
		ph_next = ph_reg;
		op_next = op_reg;
		cmd_next = cmd_reg;
		addr_next = addr_reg;
		abyte_next = abyte_reg;
		len_next = len_reg;
		cle_next = 1'b0;
		ale_next = 1'b0;
		cs_n_next = cs_n_reg;
		we_n_next = we_n_reg;
		re_n_next = 1'b1;
		wp_n_next = wp_n_reg;
		dout_next = dout_reg;
		oe_next = 1'b0;
		rdy_next = 1'b0;
		done_next = 1'b0;
		rv_next = 1'b0;
		rd_next = rd_reg;
		fout.ready = 1'b0;
		case (st_reg)
			S_IDLE: begin
				rdy_next = 1'b1;
				cs_n_next = 1'b1;
				we_n_next = 1'b1;
				cnt_next = '0;
				ph_next = 1'b0;
				if (req_valid_in && rdy_reg) begin
					rdy_next = 1'b0;
					op_next = req_op_in;
					len_next = req_len_in;
					// Row used as given: caller keeps the bad-block list and erases first
					addr_next = req_addr_in; // RULE11 RULE12
					abyte_next = '0;
					cs_n_next = 1'b0;
					// Protect lifted only for program and erase
					wp_n_next = (req_op_in == 3'(nfhc_pkg::NFHC_OP_PROGRAM)) ||
						(req_op_in == 3'(nfhc_pkg::NFHC_OP_ERASE)); // RULE8
					case (req_op_in)
						3'(nfhc_pkg::NFHC_OP_READ): cmd_next = req_cmd_in;
						3'(nfhc_pkg::NFHC_OP_PROGRAM): cmd_next = `NFHC_CMD_PROG_SETUP;
						3'(nfhc_pkg::NFHC_OP_ERASE): cmd_next = `NFHC_CMD_ERASE_SETUP;
						3'(nfhc_pkg::NFHC_OP_STATUS): cmd_next = `NFHC_CMD_STATUS;
						default: cmd_next = req_cmd_in;
					endcase
					st_next = S_CMD;
				end
			end
			S_CMD, S_CMD2: begin
				// Command strobe high across the whole write pulse
				cle_next = 1'b1; // RULE1
				oe_next = 1'b1;
				dout_next = (st_reg == S_CMD2) ? (is_erase ? `NFHC_CMD_ERASE_EXEC :
					`NFHC_CMD_PROG_EXEC) : cmd_reg;
				// Low in phase 0, rises at the phase 1 edge while the latch stays up
				we_n_next = ph_reg; // RULE3
				if (phase_end) begin
					ph_next = ~ph_reg;
					if (ph_reg) begin
						if (st_reg == S_CMD2) begin
							st_next = S_WAIT_WB;
						end else if (op_reg == 3'(nfhc_pkg::NFHC_OP_CMD) ||
							op_reg == 3'(nfhc_pkg::NFHC_OP_STATUS)) begin
							st_next = (op_reg == 3'(nfhc_pkg::NFHC_OP_STATUS)) ?
								S_RDATA : S_WAIT_WB; // RULE14
						end else begin
							st_next = S_ADDR;
						end
					end
				end
			end
			S_ADDR: begin
				ale_next = 1'b1; // RULE2
				oe_next = 1'b1;
				dout_next = addr_byte(addr_reg, abyte_reg, is_erase); // RULE13
				we_n_next = ph_reg;
				if (phase_end) begin
					ph_next = ~ph_reg;
					if (ph_reg) begin
						abyte_next = abyte_reg + 2'd1;
						// Four bytes for page ops, three for erase
						if (abyte_reg == (is_erase ? 2'd2 : 2'd3)) begin // RULE14
							if (is_erase) begin
								st_next = S_CMD2;
							end else if (op_reg == 3'(nfhc_pkg::NFHC_OP_PROGRAM)) begin
								st_next = S_WDATA;
							end else begin
								st_next = S_WAIT_WB;
							end
						end
					end
				end
			end
			S_WDATA: begin
				// Both latch strobes low, output strobe high
				oe_next = 1'b1; // RULE15
				dout_next = fout.data;
				// Stall the strobe low phase until a byte is buffered
				if (!ph_reg && !fout.valid) begin
					cnt_next = '0;
					we_n_next = 1'b1;
				end else begin
					we_n_next = ph_reg;
				end
				if (phase_end && (ph_reg || fout.valid)) begin
					ph_next = ~ph_reg;
					if (ph_reg) begin
						fout.ready = 1'b1;
						len_next = len_reg - 10'd1;
						if (len_reg == 10'd1) begin
							st_next = S_CMD2;
						end
					end
				end
			end
			S_WAIT_WB: begin
				// Busy may not show until this delay passes
				we_n_next = 1'b1;
				if (cnt_reg == `NFHC_CNT_W'(`NFHC_WB_CYC - 1)) begin
					cnt_next = '0;
					st_next = S_WAIT_RDY;
				end else begin
					cnt_next = cnt_reg + `NFHC_CNT_W'(1);
				end
			end
			S_WAIT_RDY: begin
				// Busy line sampled any time, select kept low
				cnt_next = '0;
				ph_next = 1'b0;
				if (ready_busy_in) begin // RULE9 RULE10
					st_next = (op_reg == 3'(nfhc_pkg::NFHC_OP_READ) && len_reg != '0) ?
						S_RDATA : S_DONE;
				end
			end
			S_RDATA: begin
				// Output strobe low half then high half
				re_n_next = ph_reg; // RULE6
				we_n_next = 1'b1;
				if (phase_end) begin
					ph_next = ~ph_reg;
					if (ph_reg) begin
						// Sample data at end of low phase
						rd_next = shared_byte_port_in;
						rv_next = 1'b1;
						len_next = len_reg - 10'd1;
						if (len_reg <= 10'd1) begin
							st_next = S_DONE;
						end
					end
				end
			end
			S_DONE: begin
				// Deselect; ends a read early, harmless after busy
				cs_n_next = 1'b1; // RULE4 RULE5 RULE7
				wp_n_next = 1'b0;
				done_next = 1'b1;
				st_next = S_IDLE;
			end
			default: st_next = S_IDLE;
		endcase
	end

	// ----------------------------------------
	// State registers
	// ----------------------------------------
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_reg <= S_IDLE;
			cnt_reg <= '0;
			ph_reg <= 1'b0;
			op_reg <= '0;
			cmd_reg <= '0;
			addr_reg <= '0;
			abyte_reg <= '0;
			len_reg <= '0;
			cle_reg <= 1'b0;
			ale_reg <= 1'b0;
			cs_n_reg <= 1'b1;
			we_n_reg <= 1'b1;
			re_n_reg <= 1'b1;
			wp_n_reg <= 1'b0;
			dout_reg <= '0;
			oe_reg <= 1'b0;
			rdy_reg <= 1'b0;
			done_reg <= 1'b0;
			rv_reg <= 1'b0;
			rd_reg <= '0;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			ph_reg <= ph_next;
			op_reg <= op_next;
			cmd_reg <= cmd_next;
			addr_reg <= addr_next;
			abyte_reg <= abyte_next;
			len_reg <= len_next;
			cle_reg <= cle_next;
			ale_reg <= ale_next;
			cs_n_reg <= cs_n_next;
			we_n_reg <= we_n_next;
			re_n_reg <= re_n_next;
			wp_n_reg <= wp_n_next;
			dout_reg <= dout_next;
			oe_reg <= oe_next;
			rdy_reg <= rdy_next;
			done_reg <= done_next;
			rv_reg <= rv_next;
			rd_reg <= rd_next;
		end
	end

	// ----------------------------------------
	// Outputs straight from flops
	// ----------------------------------------
	assign req_ready_out = rdy_reg;
	assign done_out = done_reg;
	assign wdata_ready_out = fin.ready;
	assign rdata_valid_out = rv_reg;
	assign rdata_out = rd_reg;
	assign cmd_latch_out = cle_reg;
	assign loc_latch_out = ale_reg;
	assign chip_sel_n_out = cs_n_reg;
	assign write_strobe_n_out = we_n_reg;
	assign output_strobe_n_out = re_n_reg;
	assign write_protect_n_out = wp_n_reg;
	assign shared_byte_port_out = dout_reg;
	assign shared_byte_port_oe_out = oe_reg;
endmodule

// *** verif/nfhc_host_properties.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// Pin protocol checker
// ----------------------------------------
module nfhc_host_properties (
	input wire logic clock_in,
	input wire logic rstn_in,
	input wire logic req_ready_out,
	input wire logic cmd_latch_out,
	input wire logic loc_latch_out,
	input wire logic chip_sel_n_out,
	input wire logic write_strobe_n_out,
	input wire logic output_strobe_n_out,
	input wire logic write_protect_n_out,
	input wire logic shared_byte_port_oe_out,
	input wire logic ready_busy_in
);
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rstn_in);
	// One strobe phase low, then back high
	sequence we_pulse;
		!write_strobe_n_out ##1 write_strobe_n_out;
	endsequence
	sequence re_pulse;
		!output_strobe_n_out ##1 output_strobe_n_out;
	endsequence
	chk_latch_excl: assert property (!(cmd_latch_out && loc_latch_out))
		else $error("both latch strobes high");
	chk_latch_sel: assert property ((cmd_latch_out || loc_latch_out) |-> !chip_sel_n_out)
		else $error("latch strobe without select");
	chk_we_pulse: assert property ($fell(write_strobe_n_out) |-> we_pulse)
		else $error("write strobe pulse wrong");
	chk_re_pulse: assert property ($fell(output_strobe_n_out) |-> re_pulse)
		else $error("output strobe pulse wrong");
	chk_read_float: assert property (
		!output_strobe_n_out |-> !shared_byte_port_oe_out && !chip_sel_n_out)
		else $error("host drives port during read");
	chk_busy_quiet: assert property (
		!ready_busy_in |-> write_strobe_n_out && output_strobe_n_out)
		else $error("strobe while busy");
	chk_busy_sel: assert property (
		!ready_busy_in && !$past(chip_sel_n_out) |-> !chip_sel_n_out)
		else $error("select dropped while busy");
	chk_idle_safe: assert property (
		req_ready_out |-> chip_sel_n_out && !write_protect_n_out)
		else $error("idle with select or write enable");
	// Latch strobes must outlast the write strobe rise by one phase
	chk_cle_hold: assert property (
		$rose(write_strobe_n_out) && $past(cmd_latch_out) |-> cmd_latch_out)
		else $error("command strobe dropped with write strobe rise");
	chk_ale_hold: assert property (
		$rose(write_strobe_n_out) && $past(loc_latch_out) |-> loc_latch_out)
		else $error("location strobe dropped with write strobe rise");
endmodule
bind nfhc_host nfhc_host_properties nfhc_host_properties_inst (.clock_in, .rstn_in,
	.req_ready_out, .cmd_latch_out, .loc_latch_out, .chip_sel_n_out, .write_strobe_n_out,
	.output_strobe_n_out, .write_protect_n_out, .shared_byte_port_oe_out, .ready_busy_in);

// *** verif/nfhc_card_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// Behavioural card, busy time scaled down
// ----------------------------------------
module nfhc_card_model #(
	parameter int BUSY_CYC = 20
) (
	input wire logic clock_in,
	input wire logic cle_in,
	input wire logic ale_in,
	input wire logic cs_n_in,
	input wire logic we_n_in,
	input wire logic re_n_in,
	input wire logic wp_n_in,
	input wire logic [7:0] port_in,
	output logic [7:0] dout_out,
	output logic drive_out,
	output logic busy_n_out
);
	logic [7:0] mem [256]; // Page register, column indexed
	logic [7:0] abyte_reg [4]; // Captured address bytes
	logic [7:0] cmd_reg = 8'h00;
	logic [7:0] col_reg = 8'h00;
	logic [7:0] erase_cnt_reg = 8'h00;
	logic stat_reg = 1'b0;
	int nadr = 0;
	int busy_len = 0;
	// Open drain low while busy, pull-up otherwise
	assign busy_n_out = (busy_len == 0);
	// Port driven only when selected and read strobe low
	assign drive_out = !cs_n_in && !re_n_in;
	// Every byte taken on write strobe rise
	always @(posedge we_n_in) if (!cs_n_in) begin
		if (cle_in) begin
			cmd_reg = port_in;
			nadr = (port_in == 8'h60) ? 1 : 0;
			stat_reg = (port_in == 8'h70);
			if ((port_in == 8'h10 || port_in == 8'hd0) && wp_n_in) busy_len = BUSY_CYC;
			if (port_in == 8'hd0 && wp_n_in) erase_cnt_reg++;
			if (port_in == 8'hff) busy_len = 3;
		end else if (ale_in) begin
			if (nadr < 4) abyte_reg[nadr] = port_in;
			if (nadr == 0) col_reg = port_in;
			nadr++;
			if (nadr == 4 && cmd_reg == 8'h00) busy_len = 5;
		end else begin
			mem[col_reg] = port_in;
			col_reg++;
		end
	end
	// Next byte and column step on read strobe fall
	always @(negedge re_n_in) if (!cs_n_in) begin
		dout_out = stat_reg ? 8'hc0 : mem[col_reg];
		col_reg++;
	end
	// Busy runs out regardless of select
	always @(posedge clock_in) if (busy_len > 0) busy_len--;
endmodule

// *** verif/nfhc_host_test.sv ***
`timescale 1ns/10ps
module nfhc_host_test;
	// ----------------------------------------
	// Stimulus and wiring
	// ----------------------------------------
	logic clock_in = 0, rstn_in = 0, req_valid_in = 0, wdata_valid_in = 0;
	logic [2:0] req_op_in = 0;
	logic [7:0] req_cmd_in = 0, wdata_in = 0, rdata_out, host_dout, card_dout, port, port_last = 0;
	logic [26:0] req_addr_in = 0;
	logic [9:0] req_len_in = 0;
	logic req_ready_out, done_out, wdata_ready_out, rdata_valid_out, cle, ale, cs_n, we_n;
	logic re_n, wp_n, oe, busy_n, card_drive;
	int fails = 0, n_checks = 0, seed = 32'ha0eaf879;
	logic [7:0] exp_q[$], got_q[$];
	always #20 clock_in = ~clock_in;
	// Released port shows a changing pattern, not the last byte
	assign port = oe ? host_dout : card_drive ? card_dout : ~port_last;
	always @(posedge clock_in) port_last <= (^port === 1'bx) ? 8'h00 : port;
	always @(negedge clock_in) if (rdata_valid_out === 1'b1) got_q.push_back(rdata_out);
	nfhc_host nfhc_host_inst (.clock_in(clock_in), .rstn_in(rstn_in), .req_valid_in(req_valid_in),
		.req_op_in(req_op_in), .req_cmd_in(req_cmd_in), .req_addr_in(req_addr_in),
		.req_len_in(req_len_in), .req_ready_out(req_ready_out), .done_out(done_out),
		.wdata_valid_in(wdata_valid_in), .wdata_in(wdata_in), .wdata_ready_out(wdata_ready_out),
		.rdata_valid_out(rdata_valid_out), .rdata_out(rdata_out), .cmd_latch_out(cle),
		.loc_latch_out(ale), .chip_sel_n_out(cs_n), .write_strobe_n_out(we_n),
		.output_strobe_n_out(re_n), .write_protect_n_out(wp_n), .shared_byte_port_in(port),
		.shared_byte_port_out(host_dout), .shared_byte_port_oe_out(oe), .ready_busy_in(busy_n));
	nfhc_card_model card_model_inst (.clock_in(clock_in), .cle_in(cle), .ale_in(ale),
		.cs_n_in(cs_n), .we_n_in(we_n), .re_n_in(re_n), .wp_n_in(wp_n), .port_in(port),
		.dout_out(card_dout), .drive_out(card_drive), .busy_n_out(busy_n));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] addr_byte(input logic [17:0] r, input int k);
		return (k == 1) ? r[7:0] : (k == 2) ? r[15:8] : {6'h00, r[17:16]}; // Top bits low
	endfunction
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task wrap_up;
		if (fails == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Request held until taken, then wait for done, bounded
	task automatic op(input logic [2:0] o, input logic [7:0] c, input logic [26:0] a,
		input logic [9:0] n);
		int k;
		req_valid_in = 1;
		req_op_in = o;
		req_cmd_in = c;
		req_addr_in = a;
		req_len_in = n;
		k = 0;
		while (req_ready_out !== 1'b1 && k < 100) begin @(negedge clock_in); k++; end
		@(negedge clock_in);
		req_valid_in = 0;
		k = 0;
		while (done_out !== 1'b1 && k < 5000) begin @(negedge clock_in); k++; end
		if (k == 5000) begin
			fails++;
			wrap_up;
		end
	endtask
	// Valid stays up across back-to-back bytes
	task automatic push(input logic [7:0] b);
		wdata_valid_in = 1;
		wdata_in = b;
		exp_q.push_back(b);
		@(negedge clock_in);
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		int i, j, n;
		logic [7:0] col, e0;
		logic [17:0] row;
		repeat (8) @(negedge clock_in);
		rstn_in = 1;
		repeat (3) @(negedge clock_in);
		for (i = 0; i < 3; i++) begin
			row = 18'($random(seed)) + 18'(i);
			n = (i == 0) ? 8 : 1 + int'($unsigned($random(seed)) % 8);
			col = (i == 0) ? 8'h00 : {1'b0, 7'($random(seed))};
			e0 = card_model_inst.erase_cnt_reg;
			op(nfhc_pkg::NFHC_OP_ERASE, 8'h00, {row, 9'h000}, 10'h001);
			chk8("erase_count", e0 + 8'h01, card_model_inst.erase_cnt_reg);
			for (j = 1; j < 4; j++) begin
				chk8("row_byte", addr_byte(row, j), card_model_inst.abyte_reg[j]);
			end
			exp_q.delete();
			for (j = 0; j < n; j++) push(8'($random(seed)));
			// Full FIFO refuses the ninth byte
			if (i == 0) chk8("fifo_ready", 8'h00, {7'h00, wdata_ready_out});
			if (i == 0) @(negedge clock_in);
			wdata_valid_in = 0;
			op(nfhc_pkg::NFHC_OP_PROGRAM, 8'h00, {row, 1'b0, col}, 10'(n));
			chk8("col_byte", col, card_model_inst.abyte_reg[0]);
			chk8("top_byte", addr_byte(row, 3), card_model_inst.abyte_reg[3]);
			got_q.delete();
			op(nfhc_pkg::NFHC_OP_READ, 8'h00, {row, 1'b0, col}, 10'(n));
			for (j = 0; j < n; j++) chk8("read_data", exp_q[j], got_q[j]);
		end
		got_q.delete();
		op(nfhc_pkg::NFHC_OP_STATUS, 8'h70, 27'h0000000, 10'h001);
		chk8("status", 8'hc0, got_q[0]);
		op(nfhc_pkg::NFHC_OP_CMD, 8'hff, 27'h0000000, 10'h001);
		chk8("command", 8'hff, card_model_inst.cmd_reg);
		wrap_up;
	end
	initial begin
		#(40 * 60000);
		fails++;
		wrap_up;
	end
endmodule
